//--- wdr_pkg.sv
package wdr_pkg;

	// Counter geometry
	localparam int CNT_W = 24;
	localparam logic [CNT_W-1:0] RELOAD_RST = 24'hffffff;

	// Register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_RELOAD = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_REFRESH = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h10;

	// Field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_RESP_BIT = 1;
	localparam int STAT_WDT_BIT = 0;
	localparam int STAT_STOP_BIT = 1;

	// Reset values
	localparam logic CTRL_EN_RST = 1'b0;

	// Option encoding of the time-out response
	localparam logic RESP_RESET = 1'b0;
	localparam logic RESP_IRQ = 1'b1;

	// Width of the system reset pulse
	localparam int CLK_PERIOD_NS = 10;
	localparam int RST_HOLD_NS = 40;
	localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W = 4;

	// Reset status flags
	typedef struct packed {
		logic stop;
		logic wdt;
	} wdr_stat_t;

	// Counter sequencing
	typedef enum logic [1:0] {
		WDR_IDLE,
		WDR_RUN,
		WDR_RESET
	} wdr_state_t;

endpackage

//--- wdr_watchdog.sv
// Contract
// - On the first enable the counter is loaded from the reload register before counting.
// - The counter decrements toward zero unless a refresh comes first.
// - Each refresh reloads the counter from the reload register and counting resumes.
// - In debug mode the counter is refreshed every cycle so no time-out occurs.
// - A time-out is declared when the counter value is zero.
// - A time-out gives an interrupt request or a system reset, chosen by an option bit.
// - In interrupt response a time-out requests an interrupt and sets the time-out flag.
// - After an interrupt time-out the counter wraps to all ones and keeps counting down.
// - Reading the reset status register clears the time-out flag.
// - In interrupt response during stop mode a time-out starts stop recovery and an interrupt.
// - In interrupt response a stop-mode time-out sets both the time-out flag and the stop-recovery flag.
// - After a stop wake the interrupt is delivered only once recovery ends and if enabled.
`timescale 1ns/1ps
`default_nettype none

module wdr_watchdog (
	input wire logic core_clk, // System clock
	input wire logic rstn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [wdr_pkg::ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic watchdog_refresh_instruction, // Refresh pulse from the core
	input wire logic timeout_response_select, // Option bit, 1 selects interrupt
	input wire logic debug_mode, // Debugger active, asynchronous pin
	input wire logic stop_mode, // Core is in stop mode
	input wire logic stop_recovery_done, // Stop recovery has completed
	input wire logic irq_global_en, // Interrupts globally enabled
	input wire logic irq_ack, // Controller clears the pending request
	output logic wdt_irq, // Interrupt request to the controller
	output logic stop_recovery_start, // Starts a stop-mode recovery
	output logic sys_reset_out // System reset request, active high
);

	localparam logic [wdr_pkg::CNT_W-1:0] CNT_ONES = '1;
	localparam logic [wdr_pkg::RST_CNT_W-1:0] RST_LEN =
		wdr_pkg::RST_CNT_W'(wdr_pkg::RST_HOLD_CYC);

	// Register decode helper
	function automatic logic hit(input logic [wdr_pkg::ADDR_W-1:0] a,
		input logic [wdr_pkg::ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	wdr_pkg::wdr_state_t state_ff, nxt_state;
	logic [wdr_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [wdr_pkg::CNT_W-1:0] reload_ff, nxt_reload;
	logic en_ff, nxt_en;
	logic resp_ff;
	logic dbg_s1_ff, dbg_s2_ff;
	wdr_pkg::wdr_stat_t stat_ff, nxt_stat;
	logic pend_ff, nxt_pend;
	logic recov_ff, nxt_recov;
	logic [wdr_pkg::RST_CNT_W-1:0] rst_cnt_ff, nxt_rst_cnt;
	logic [31:0] rdata_ff, nxt_rdata;
	logic wr_fire, rd_fire, setup, mapped, sw_refresh, refresh, timeout, stat_rd;

	// Bus phases
	assign setup = psel && !penable;
	assign wr_fire = psel && penable && pwrite;
	assign rd_fire = psel && penable && !pwrite;
	assign mapped = hit(paddr, wdr_pkg::OFF_CTRL) || hit(paddr, wdr_pkg::OFF_RELOAD) ||
		hit(paddr, wdr_pkg::OFF_REFRESH) || hit(paddr, wdr_pkg::OFF_STATUS) ||
		hit(paddr, wdr_pkg::OFF_COUNT);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = rdata_ff;
	assign sw_refresh = wr_fire && hit(paddr, wdr_pkg::OFF_REFRESH);
	assign stat_rd = rd_fire && hit(paddr, wdr_pkg::OFF_STATUS);
	assign refresh = watchdog_refresh_instruction || sw_refresh || dbg_s2_ff;
	assign timeout = (state_ff == wdr_pkg::WDR_RUN) && (cnt_ff == '0) && !refresh;

	// Debug pin synchroniser and option bit capture
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			dbg_s1_ff <= 1'b0;
			dbg_s2_ff <= 1'b0;
			resp_ff <= wdr_pkg::RESP_RESET;
		end else begin
			dbg_s1_ff <= debug_mode;
			dbg_s2_ff <= dbg_s1_ff;
			resp_ff <= timeout_response_select;
		end
	end

	// Software registers written in the access cycle, read data captured in the setup cycle
	always_comb begin
		nxt_en = en_ff;
		nxt_reload = reload_ff;
		nxt_rdata = rdata_ff;
		if (wr_fire && hit(paddr, wdr_pkg::OFF_CTRL)) begin
			nxt_en = pwdata[wdr_pkg::CTRL_EN_BIT];
		end
		if (wr_fire && hit(paddr, wdr_pkg::OFF_RELOAD)) begin
			nxt_reload = pwdata[wdr_pkg::CNT_W-1:0];
		end
		if (setup && !pwrite) begin
			nxt_rdata = '0;
			case (paddr)
				wdr_pkg::OFF_CTRL: begin
					nxt_rdata[wdr_pkg::CTRL_EN_BIT] = en_ff;
					nxt_rdata[wdr_pkg::CTRL_RESP_BIT] = resp_ff;
				end
				wdr_pkg::OFF_RELOAD: nxt_rdata[wdr_pkg::CNT_W-1:0] = reload_ff;
				wdr_pkg::OFF_STATUS: begin
					nxt_rdata[wdr_pkg::STAT_WDT_BIT] = stat_ff.wdt;
					nxt_rdata[wdr_pkg::STAT_STOP_BIT] = stat_ff.stop;
				end
				wdr_pkg::OFF_COUNT: nxt_rdata[wdr_pkg::CNT_W-1:0] = cnt_ff;
				default: nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			en_ff <= wdr_pkg::CTRL_EN_RST;
			reload_ff <= wdr_pkg::RELOAD_RST;
			rdata_ff <= '0;
		end else begin
			en_ff <= nxt_en;
			reload_ff <= nxt_reload;
			rdata_ff <= nxt_rdata;
		end
	end

	// Counter sequencing
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_rst_cnt = rst_cnt_ff;
		case (state_ff)
			wdr_pkg::WDR_IDLE: begin
				if (en_ff) begin
					nxt_cnt = reload_ff;
					nxt_state = wdr_pkg::WDR_RUN;
				end
			end
			wdr_pkg::WDR_RUN: begin
				if (!en_ff) begin
					nxt_state = wdr_pkg::WDR_IDLE;
				end else if (refresh) begin
					nxt_cnt = reload_ff;
				end else if (timeout && resp_ff == wdr_pkg::RESP_IRQ) begin
					nxt_cnt = CNT_ONES;
				end else if (timeout) begin
					nxt_cnt = reload_ff;
					nxt_rst_cnt = RST_LEN;
					nxt_state = wdr_pkg::WDR_RESET;
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			wdr_pkg::WDR_RESET: begin
				nxt_rst_cnt = rst_cnt_ff - 1'b1;
				if (rst_cnt_ff == 4'h1) begin
					nxt_state = wdr_pkg::WDR_IDLE;
				end
			end
			default: nxt_state = wdr_pkg::WDR_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= wdr_pkg::WDR_IDLE;
			cnt_ff <= wdr_pkg::RELOAD_RST;
			rst_cnt_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			rst_cnt_ff <= nxt_rst_cnt;
		end
	end

	// Status flags, pending request and stop recovery; a new event beats a clear
	always_comb begin
		nxt_stat = stat_ff;
		nxt_pend = pend_ff;
		nxt_recov = recov_ff;
		if (stat_rd) begin
			nxt_stat.wdt = stat_ff.wdt && !rdata_ff[wdr_pkg::STAT_WDT_BIT];
			nxt_stat.stop = stat_ff.stop && !rdata_ff[wdr_pkg::STAT_STOP_BIT];
		end
		if (irq_ack) begin
			nxt_pend = 1'b0;
		end
		if (stop_recovery_done) begin
			nxt_recov = 1'b0;
		end
		if (timeout) begin
			nxt_stat.wdt = 1'b1;
			if (resp_ff == wdr_pkg::RESP_IRQ) begin
				nxt_pend = 1'b1;
				if (stop_mode) begin
					nxt_stat.stop = 1'b1;
					nxt_recov = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			stat_ff <= '0;
			pend_ff <= 1'b0;
			recov_ff <= 1'b0;
		end else begin
			stat_ff <= nxt_stat;
			pend_ff <= nxt_pend;
			recov_ff <= nxt_recov;
		end
	end

	// Outgoing requests
	assign wdt_irq = pend_ff && !recov_ff && irq_global_en;
	assign stop_recovery_start = timeout && resp_ff == wdr_pkg::RESP_IRQ && stop_mode;
	assign sys_reset_out = (state_ff == wdr_pkg::WDR_RESET);

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	a_first_load: assert property ((state_ff == wdr_pkg::WDR_IDLE) && en_ff |=>
		cnt_ff == $past(reload_ff)) else $error("counter not loaded on enable");
	a_count_down: assert property ((state_ff == wdr_pkg::WDR_RUN) && en_ff && !refresh &&
		cnt_ff != '0 |=> cnt_ff == $past(cnt_ff) - 1'b1) else $error("counter did not step down");
	a_refresh_load: assert property ((state_ff == wdr_pkg::WDR_RUN) && en_ff &&
		watchdog_refresh_instruction |=> cnt_ff == $past(reload_ff)) else $error("refresh lost");
	a_debug_hold: assert property ((state_ff == wdr_pkg::WDR_RUN) && en_ff && dbg_s2_ff |=>
		cnt_ff == $past(reload_ff)) else $error("time-out during debug");
	a_zero_flag: assert property ((state_ff == wdr_pkg::WDR_RUN) && cnt_ff == '0 &&
		!refresh |=> stat_ff.wdt) else $error("zero count gave no time-out flag");
	a_irq_resp: assert property (timeout && resp_ff == wdr_pkg::RESP_IRQ && en_ff |=>
		pend_ff && !sys_reset_out && cnt_ff == CNT_ONES) else $error("bad interrupt response");
	a_wrap_down: assert property (timeout && resp_ff == wdr_pkg::RESP_IRQ && en_ff
		##1 en_ff && !refresh |=> cnt_ff == CNT_ONES - 1'b1)
		else $error("no count after wrap");
	a_read_clear: assert property (stat_rd && rdata_ff[wdr_pkg::STAT_WDT_BIT] && !timeout |=>
		!stat_ff.wdt) else $error("status read did not clear flag");
	a_stop_wake: assert property (stop_recovery_start |=> stat_ff.wdt && stat_ff.stop &&
		recov_ff) else $error("stop time-out flags missing");
	a_irq_gate: assert property (wdt_irq |-> !recov_ff && irq_global_en)
		else $error("interrupt during recovery");
	a_reset_pulse: assert property (timeout && resp_ff == wdr_pkg::RESP_RESET && en_ff |=>
		sys_reset_out[*4] ##1 !sys_reset_out) else $error("bad reset pulse");

	// Bus side effects
	a_reload_wr: assert property (wr_fire && hit(paddr, wdr_pkg::OFF_RELOAD) |=>
		reload_ff == $past(pwdata[wdr_pkg::CNT_W-1:0])) else $error("reload write lost");
	a_en_wr: assert property (wr_fire && hit(paddr, wdr_pkg::OFF_CTRL) |=>
		en_ff == $past(pwdata[wdr_pkg::CTRL_EN_BIT])) else $error("enable write lost");
	a_bad_addr: assert property (psel && penable && !mapped |-> pslverr)
		else $error("unmapped access not refused");
	a_count_read: assert property (setup && !pwrite && hit(paddr, wdr_pkg::OFF_COUNT) |=>
		prdata[wdr_pkg::CNT_W-1:0] == $past(cnt_ff)) else $error("count read wrong");

	// Response sequencing
	a_reset_cause: assert property (timeout && resp_ff == wdr_pkg::RESP_RESET |=>
		stat_ff.wdt) else $error("reset cause not recorded");
	a_irq_no_reset: assert property (timeout && resp_ff == wdr_pkg::RESP_IRQ |=>
		!sys_reset_out) else $error("reset in interrupt response");
	a_wake_quiet: assert property (stop_recovery_start |=> !wdt_irq)
		else $error("interrupt before recovery done");
	a_srs_gate: assert property (stop_recovery_start |->
		timeout && stop_mode && resp_ff == wdr_pkg::RESP_IRQ) else $error("stray recovery start");
	a_reset_end: assert property ((state_ff == wdr_pkg::WDR_RESET) && rst_cnt_ff == 4'h1 |=>
		state_ff == wdr_pkg::WDR_IDLE) else $error("reset state did not end");
	a_reset_count: assert property ((state_ff == wdr_pkg::WDR_RESET) |-> rst_cnt_ff != '0)
		else $error("reset length counter empty");

	// Held state
	a_ack_clear: assert property (irq_ack && !timeout |=> !pend_ff)
		else $error("acknowledge did not clear request");
	a_recov_clear: assert property (stop_recovery_done && !stop_recovery_start |=> !recov_ff)
		else $error("recovery flag not cleared");
	a_flag_hold: assert property (!timeout && !stat_rd |=> stat_ff == $past(stat_ff))
		else $error("status changed on its own");
	a_pend_hold: assert property (!timeout && !irq_ack |=> pend_ff == $past(pend_ff))
		else $error("pending request changed on its own");
	a_rdata_hold: assert property (!(setup && !pwrite) |=> rdata_ff == $past(rdata_ff))
		else $error("read data changed outside a read");
	a_recov_hold: assert property (!stop_recovery_start && !stop_recovery_done |=>
		recov_ff == $past(recov_ff)) else $error("recovery flag changed on its own");

	c_irq_timeout: cover property (timeout && resp_ff == wdr_pkg::RESP_IRQ);
	c_reset_timeout: cover property (timeout && resp_ff == wdr_pkg::RESP_RESET);
	c_stop_wake: cover property (stop_recovery_start ##[1:50] stop_recovery_done);
	c_status_read: cover property (stat_rd && rdata_ff[wdr_pkg::STAT_WDT_BIT]);
	c_debug_refresh: cover property ((state_ff == wdr_pkg::WDR_RUN) && dbg_s2_ff);

endmodule

`default_nettype wire

//--- wdr_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module wdr_core_model (
	input wire logic core_clk, // System clock
	input wire logic rstn, // Async reset, active low
	input wire logic keep_alive, // Refresh periodically while high
	input wire logic status_read, // Software has read the status register
	input wire logic wdt_irq, // Request from the watchdog
	output logic watchdog_refresh_instruction, // Refresh pulse
	output logic irq_ack // Clears the pending request
);
	logic [1:0] tick_ff;
	logic [1:0] nxt_tick;
	logic seen_ff;
	logic nxt_seen;
	logic ack_ff;
	logic nxt_ack;
	// Refresh every fourth cycle; ack only once the status read was seen
	always_comb begin
		nxt_tick = keep_alive ? tick_ff + 2'h1 : 2'h0;
		nxt_seen = (seen_ff | status_read) & ~ack_ff;
		nxt_ack = seen_ff & wdt_irq & ~ack_ff;
	end
	// State registers
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tick_ff <= 2'h0;
			seen_ff <= 1'b0;
			ack_ff <= 1'b0;
		end else begin
			tick_ff <= nxt_tick;
			seen_ff <= nxt_seen;
			ack_ff <= nxt_ack;
		end
	end
	assign watchdog_refresh_instruction = keep_alive & (tick_ff == 2'h3);
	assign irq_ack = ack_ff;
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk, rstn, psel, penable, pwrite, sel, dbg, stp, sdone, gen, ka, sread, err, seen;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, refr, ack, irq, srs, rso;
	int miscompares, num_checks, n;
	wdr_watchdog uut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .watchdog_refresh_instruction(refr), .timeout_response_select(sel),
		.debug_mode(dbg), .stop_mode(stp), .stop_recovery_done(sdone), .irq_global_en(gen),
		.irq_ack(ack), .wdt_irq(irq), .stop_recovery_start(srs), .sys_reset_out(rso));
	wdr_core_model core (.core_clk(core_clk), .rstn(rstn), .keep_alive(ka),
		.status_read(sread), .wdt_irq(irq), .watchdog_refresh_instruction(refr), .irq_ack(ack));
	// Clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// One APB transfer, then one idle edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge core_clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	// Wait on negedges until the chosen output is high
	task wait_hi(input int which);
		n = 0;
		while ((which == 0 ? irq : which == 1 ? srs : rso) !== 1'b1 && n < 40) begin
			@(negedge core_clk);
			n++;
		end
	endtask
	// Watch for any time-out over k cycles
	task hold(input int k);
		seen = 1'b0;
		repeat (k) begin
			@(negedge core_clk);
			seen = seen | irq | srs | rso;
		end
	endtask
	task pulse_read;
		@(posedge core_clk);
		sread <= 1'b1;
		@(posedge core_clk);
		sread <= 1'b0;
	endtask
	task t_reset;
		apb(1'b0, wdr_pkg::OFF_CTRL, 32'h0);
		chk(rd, 32'h2, "ctrl reset");
		apb(1'b0, wdr_pkg::OFF_COUNT, 32'h0);
		chk(rd, 32'h00ffffff, "count reset");
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped error");
		chk({31'h0, pready}, 32'h1, "ready");
		apb(1'b1, wdr_pkg::OFF_RELOAD, 32'hff000008);
		apb(1'b0, wdr_pkg::OFF_RELOAD, 32'h0);
		chk(rd, 32'h8, "reload width");
		$display("reset test done");
	endtask
	task t_irq;
		apb(1'b1, wdr_pkg::OFF_CTRL, 32'h1);
		wait_hi(0);
		chk(32'(n), 32'd10, "first time-out");
		apb(1'b0, wdr_pkg::OFF_COUNT, 32'h0);
		chk({28'h0, rd[23:20]}, 32'hf, "wrap");
		apb(1'b0, wdr_pkg::OFF_STATUS, 32'h0);
		chk(rd, 32'h1, "flag set");
		apb(1'b0, wdr_pkg::OFF_STATUS, 32'h0);
		chk(rd, 32'h0, "flag cleared");
		pulse_read();
		hold(5);
		chk({31'h0, irq}, 32'h0, "ack clears");
		$display("irq test done");
	endtask
	task t_refresh;
		apb(1'b1, wdr_pkg::OFF_REFRESH, 32'h0);
		ka <= 1'b1;
		hold(40);
		chk({31'h0, seen}, 32'h0, "core refresh");
		apb(1'b1, wdr_pkg::OFF_REFRESH, 32'h0);
		ka <= 1'b0;
		dbg <= 1'b1;
		hold(40);
		chk({31'h0, seen}, 32'h0, "debug refresh");
		@(posedge core_clk);
		dbg <= 1'b0;
		wait_hi(0);
		chk({31'h0, irq}, 32'h1, "time-out after debug");
		apb(1'b0, wdr_pkg::OFF_STATUS, 32'h0);
		pulse_read();
		hold(5);
		$display("refresh test done");
	endtask
	task t_stop;
		@(posedge core_clk);
		stp <= 1'b1;
		apb(1'b1, wdr_pkg::OFF_REFRESH, 32'h0);
		wait_hi(1);
		chk({31'h0, srs}, 32'h1, "recovery start");
		hold(3);
		chk({31'h0, irq}, 32'h0, "held in recovery");
		apb(1'b0, wdr_pkg::OFF_STATUS, 32'h0);
		chk(rd, 32'h3, "both flags");
		gen <= 1'b0;
		sdone <= 1'b1;
		@(posedge core_clk);
		sdone <= 1'b0;
		stp <= 1'b0;
		hold(2);
		chk({31'h0, irq}, 32'h0, "globally off");
		@(posedge core_clk);
		gen <= 1'b1;
		hold(1);
		chk({31'h0, irq}, 32'h1, "delivered");
		pulse_read();
		hold(5);
		$display("stop test done");
	endtask
	task t_rstmode;
		@(posedge core_clk);
		sel <= 1'b0;
		hold(2);
		apb(1'b1, wdr_pkg::OFF_REFRESH, 32'h0);
		wait_hi(2);
		n = 0;
		while (rso === 1'b1 && n < 10) begin
			@(negedge core_clk);
			n++;
		end
		chk(32'(n), 32'd4, "reset width");
		chk({31'h0, irq}, 32'h0, "no irq");
		apb(1'b0, wdr_pkg::OFF_STATUS, 32'h0);
		chk(rd, 32'h1, "cause recorded");
		$display("reset mode test done");
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		#100000;
		miscompares++;
		stop_test();
	end
	// Main sequence
	initial begin
		{rstn, psel, penable, pwrite, dbg, stp, sdone, ka, sread} = '0;
		{sel, gen} = 2'h3;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_irq();
		t_refresh();
		t_stop();
		t_rstmode();
		stop_test();
	end
endmodule
`default_nettype wire
